// *** spr_consts.svh ***
/*
 * register offsets, field positions and reset values of the lane PLL and
 * termination calibration register group.
 * assumes a 12-bit register address from the serial register port.
 */
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

// register offsets
`define SPR_ADDR_PLL_CONTROL 12'h280
`define SPR_ADDR_PLL_STATUS 12'h281
`define SPR_ADDR_REFCLK_DIVIDER 12'h289
`define SPR_ADDR_TERM_CAL_CONTROL_A 12'h2a7
`define SPR_ADDR_TERM_OVERRIDE_A 12'h2a8

// pll_control fields
`define SPR_CTL_POWER_ENABLE_BIT 0
`define SPR_CTL_RSVD_RW_BIT 1
`define SPR_CTL_RECAL_BIT 2

// pll_status fields
`define SPR_STS_LOCKED_BIT 0
`define SPR_STS_CAL_VALID_BIT 3
`define SPR_STS_BELOW_BIT 4
`define SPR_STS_ABOVE_BIT 5

// refclk_divider and termination fields
`define SPR_DIV_SEL_MSB 1
`define SPR_TERM_CAL_TRIG_BIT 0
`define SPR_OVR_ENABLE_BIT 4
`define SPR_OVR_VALUE_MSB 3
`define SPR_OVR_VALUE_LSB 1

// reset values
`define SPR_RST_BYTE 8'h00
`define SPR_RST_CODE 3'h0

`endif

// *** spr_pkg.sv ***
/*
 * types shared by the lane PLL and termination register group.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package spr_pkg;

    // reference predivider select codes, named by the lane-rate band served
    typedef enum logic [1:0] {
        SPR_BAND_6G_12G5 = 2'h0,
        SPR_BAND_3G_6G = 2'h1,
        SPR_BAND_1G5_3G = 2'h2,
        SPR_BAND_UNUSED = 2'h3
    } spr_prediv_t;

    typedef logic [7:0] spr_byte_t;

endpackage : spr_pkg

// *** spr_regs.sv ***
/*
 * spr_regs: software-visible control and status bytes of the lane PLL and
 * the first termination calibration group.
 * assumes the serial register port engine delivers decoded byte accesses
 * on i_core_clk; analog status and the calibrated code come from outside
 * this clock domain and are synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none
`include "spr_consts.svh"

module spr_regs
    import spr_pkg::*;
(
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [11:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // analog status from the lane PLL
    input wire logic i_pll_locked,
    input wire logic i_pump_cal_valid,
    input wire logic i_pump_below_range,
    input wire logic i_pump_above_range,
    // calibrated termination code from the calibration engine
    input wire logic [2:0] i_term_cal_code_a,
    // controls towards the lane PLL
    output logic o_pll_power_enable,
    output logic o_pll_recal_pulse,
    output spr_prediv_t o_refclk_predivider_select,
    // controls towards the first termination group
    output logic o_term_cal_start_a,
    output logic o_term_override_a,
    output logic [2:0] o_term_value_a
);

    // stored register bytes
    spr_byte_t pll_control_q;
    spr_byte_t refclk_divider_q;
    spr_byte_t term_cal_control_a_q;
    spr_byte_t term_override_a_q;
    // synchroniser stages for the analog side
    logic [3:0] sts_meta_q;
    logic [3:0] sts_sync_q;
    logic [2:0] code_meta_q;
    logic [2:0] code_sync_q;
    // trigger edge state
    logic recal_prev_q;
    logic term_prev_q;
    logic recal_pulse_q;
    logic term_pulse_q;
    // output flops and the combinational status byte
    logic [7:0] rdata_q;
    logic pwr_q;
    spr_prediv_t prediv_q;
    logic ovr_q;
    logic [2:0] tval_q;
    spr_byte_t pll_status_d;

    // rising edge of a trigger bit against its previous sample
    function automatic logic rose(input logic cur, input logic prev);
        rose = cur & ~prev;
    endfunction : rose

    // write decode for one register offset
    function automatic logic wr_hit(input logic [11:0] addr, input logic [11:0] reg_addr,
                                    input logic wr);
        wr_hit = wr && (addr == reg_addr);
    endfunction : wr_hit

    // pll_control: bits 2:0 stored, bits 7:3 read zero
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pll_control_q <= `SPR_RST_BYTE;
        end else if (wr_hit(i_reg_addr, `SPR_ADDR_PLL_CONTROL, i_reg_wr)) begin
            pll_control_q <= `SPR_RST_BYTE;
            pll_control_q[`SPR_CTL_POWER_ENABLE_BIT] <=
                i_reg_wdata[`SPR_CTL_POWER_ENABLE_BIT];
            pll_control_q[`SPR_CTL_RSVD_RW_BIT] <= i_reg_wdata[`SPR_CTL_RSVD_RW_BIT];
            pll_control_q[`SPR_CTL_RECAL_BIT] <= i_reg_wdata[`SPR_CTL_RECAL_BIT];
        end
    end

    // refclk_divider: only the predivider select is stored
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            refclk_divider_q <= `SPR_RST_BYTE;
        end else if (wr_hit(i_reg_addr, `SPR_ADDR_REFCLK_DIVIDER, i_reg_wr)) begin
            refclk_divider_q <= {6'h00, i_reg_wdata[`SPR_DIV_SEL_MSB:0]};
        end
    end

    // termination trigger byte: only bit 0 is stored
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            term_cal_control_a_q <= `SPR_RST_BYTE;
        end else if (wr_hit(i_reg_addr, `SPR_ADDR_TERM_CAL_CONTROL_A, i_reg_wr)) begin
            term_cal_control_a_q <= {7'h00, i_reg_wdata[`SPR_TERM_CAL_TRIG_BIT]};
        end
    end

    // override byte: all eight bits stored and read back
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            term_override_a_q <= `SPR_RST_BYTE;
        end else if (wr_hit(i_reg_addr, `SPR_ADDR_TERM_OVERRIDE_A, i_reg_wr)) begin
            term_override_a_q <= i_reg_wdata;
        end
    end

    // two-flop synchronisers for the analog status and calibrated code
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sts_meta_q <= 4'h0;
            sts_sync_q <= 4'h0;
            code_meta_q <= `SPR_RST_CODE;
            code_sync_q <= `SPR_RST_CODE;
        end else begin
            sts_meta_q <= {i_pump_above_range, i_pump_below_range, i_pump_cal_valid,
                           i_pll_locked};
            sts_sync_q <= sts_meta_q;
            code_meta_q <= i_term_cal_code_a;
            code_sync_q <= code_meta_q;
        end
    end

    // status byte assembled from synchronised levels; reserved bits zero
    always_comb begin
        pll_status_d = `SPR_RST_BYTE;
        pll_status_d[`SPR_STS_LOCKED_BIT] = sts_sync_q[0];
        pll_status_d[`SPR_STS_CAL_VALID_BIT] = sts_sync_q[1];
        pll_status_d[`SPR_STS_BELOW_BIT] = sts_sync_q[2];
        pll_status_d[`SPR_STS_ABOVE_BIT] = sts_sync_q[3];
    end

    // trigger edge detection: one pulse per 0-to-1 change
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            recal_prev_q <= 1'b0;
            term_prev_q <= 1'b0;
            recal_pulse_q <= 1'b0;
            term_pulse_q <= 1'b0;
        end else begin
            recal_prev_q <= pll_control_q[`SPR_CTL_RECAL_BIT];
            term_prev_q <= term_cal_control_a_q[`SPR_TERM_CAL_TRIG_BIT];
            recal_pulse_q <= rose(pll_control_q[`SPR_CTL_RECAL_BIT], recal_prev_q);
            term_pulse_q <= rose(term_cal_control_a_q[`SPR_TERM_CAL_TRIG_BIT],
                                 term_prev_q);
        end
    end

    // pll-facing level outputs, each from its own flop
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pwr_q <= 1'b0;
            prediv_q <= SPR_BAND_6G_12G5;
        end else begin
            pwr_q <= pll_control_q[`SPR_CTL_POWER_ENABLE_BIT];
            prediv_q <= spr_prediv_t'(refclk_divider_q[`SPR_DIV_SEL_MSB:0]);
        end
    end

    // termination-facing outputs: forced code or the calibrated one
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            ovr_q <= 1'b0;
            tval_q <= `SPR_RST_CODE;
        end else begin
            ovr_q <= term_override_a_q[`SPR_OVR_ENABLE_BIT];
            if (term_override_a_q[`SPR_OVR_ENABLE_BIT]) begin
                // forced code, 000 for xxx1000x
                tval_q <= term_override_a_q[`SPR_OVR_VALUE_MSB:`SPR_OVR_VALUE_LSB];
            end else begin
                tval_q <= code_sync_q;
            end
        end
    end

    // registered read data; unmapped offsets read zero
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rdata_q <= `SPR_RST_BYTE;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `SPR_ADDR_PLL_CONTROL: rdata_q <= pll_control_q;
                `SPR_ADDR_PLL_STATUS: rdata_q <= pll_status_d;
                `SPR_ADDR_REFCLK_DIVIDER: rdata_q <= refclk_divider_q;
                `SPR_ADDR_TERM_CAL_CONTROL_A: rdata_q <= term_cal_control_a_q;
                `SPR_ADDR_TERM_OVERRIDE_A: rdata_q <= term_override_a_q;
                default: rdata_q <= `SPR_RST_BYTE;
            endcase
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_pll_power_enable = pwr_q;
    assign o_pll_recal_pulse = recal_pulse_q;
    assign o_refclk_predivider_select = prediv_q;
    assign o_term_cal_start_a = term_pulse_q;
    assign o_term_override_a = ovr_q;
    assign o_term_value_a = tval_q;

endmodule : spr_regs

`default_nettype wire

// *** spr_regs_assertions.sv ***
/* spr_regs_chk: port-level checks of the lane PLL and termination register group.
   assumes spr_pkg compiled first; bound to every spr_regs instance. */
`timescale 1ns/100ps
`default_nettype none
module spr_regs_chk
    import spr_pkg::*;
(
    // clock, reset and register port
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [11:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata,
    // controls out
    input wire logic o_pll_power_enable,
    input wire logic o_pll_recal_pulse,
    input wire logic o_term_cal_start_a,
    input wire logic o_term_override_a,
    input wire spr_prediv_t o_refclk_predivider_select,
    input wire logic [2:0] o_term_value_a
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // trigger pulses: one cycle, caused by a write two edges back
    property p_recal_once; o_pll_recal_pulse |=> !o_pll_recal_pulse; endproperty
    a_recal_once: assert property (p_recal_once) else $error("recal pulse too long");
    property p_recal_src; o_pll_recal_pulse |-> $past(i_reg_wr, 2) &&
        $past(i_reg_addr, 2) == 12'h280 && $past(i_reg_wdata[2], 2); endproperty
    a_recal_src: assert property (p_recal_src) else $error("recal pulse without write");
    property p_tcal_src; o_term_cal_start_a |-> $past(i_reg_wr, 2) &&
        $past(i_reg_addr, 2) == 12'h2a7 && $past(i_reg_wdata[0], 2) ##1 !o_term_cal_start_a;
    endproperty
    a_tcal_src: assert property (p_tcal_src) else $error("bad termination start");
    // level outputs follow their register two edges after the write
    property p_pwr; i_reg_wr && i_reg_addr == 12'h280 |->
        ##2 o_pll_power_enable == $past(i_reg_wdata[0], 2); endproperty
    a_pwr: assert property (p_pwr) else $error("power enable wrong");
    property p_div; i_reg_wr && i_reg_addr == 12'h289 |->
        ##2 o_refclk_predivider_select == $past(i_reg_wdata[1:0], 2); endproperty
    a_div: assert property (p_div) else $error("predivider wrong");
    property p_ovr; i_reg_wr && i_reg_addr == 12'h2a8 |->
        ##2 o_term_override_a == $past(i_reg_wdata[4], 2); endproperty
    a_ovr: assert property (p_ovr) else $error("override wrong");
    property p_force; i_reg_wr && i_reg_addr == 12'h2a8 && i_reg_wdata[4] |->
        ##2 o_term_value_a == $past(i_reg_wdata[3:1], 2); endproperty
    a_force: assert property (p_force) else $error("forced code wrong");
    // read answers
    property p_rd_sts; i_reg_rd && i_reg_addr == 12'h281 |=>
        o_reg_rdata[7:6] == 2'h0 && o_reg_rdata[2:1] == 2'h0; endproperty
    a_rd_sts: assert property (p_rd_sts) else $error("status spare bits set");
    property p_rd_unm; i_reg_rd && i_reg_addr > 12'h2a8 |=> o_reg_rdata == 8'h00; endproperty
    a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
    property p_hold; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    c_recal: cover property (o_pll_recal_pulse);
    c_tcal: cover property (o_term_cal_start_a);
    c_ovr: cover property (o_term_override_a ##1 !o_term_override_a);
endmodule : spr_regs_chk
bind spr_regs spr_regs_chk u_spr_regs_chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .o_pll_power_enable(o_pll_power_enable), .o_pll_recal_pulse(o_pll_recal_pulse),
    .o_term_cal_start_a(o_term_cal_start_a), .o_term_override_a(o_term_override_a),
    .o_refclk_predivider_select(o_refclk_predivider_select), .o_term_value_a(o_term_value_a));
`default_nettype wire

// *** tb_serdes_pll_term_cal_regs.sv ***
/* tb_serdes_pll_term_cal_regs: self-checking bench of spr_regs.
   assumes spr_pkg and the checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
module tb_serdes_pll_term_cal_regs;
    import spr_pkg::*;
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rv = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wd = 8'h00, r, exq[$];
    logic [3:0] sts = 4'h0;
    logic [2:0] code = 3'h0, tv;
    logic rdy_pwr, rc, tc, ovr;
    logic [7:0] rdata;
    spr_prediv_t div;
    logic [11:0] ra[6] = '{12'h280, 12'h281, 12'h289, 12'h2a7, 12'h2a8, 12'h300};
    int err_total = 0, n_checks = 0, n_rc = 0, n_tc = 0;
    integer seed = 32'hadd7;
    always #25 clk = ~clk;
    spr_regs u_spr_regs (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata), .i_pll_locked(sts[0]),
        .i_pump_cal_valid(sts[1]), .i_pump_below_range(sts[2]), .i_pump_above_range(sts[3]),
        .i_term_cal_code_a(code), .o_pll_power_enable(rdy_pwr), .o_pll_recal_pulse(rc),
        .o_refclk_predivider_select(div), .o_term_cal_start_a(tc),
        .o_term_override_a(ovr), .o_term_value_a(tv));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wreg(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wd = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wreg
    // read request, expected byte noted for the monitor
    task automatic rreg(input logic [11:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        exq.push_back(e);
        @(negedge clk);
        rd = 1'b0;
    endtask : rreg
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    // monitor: read answers against oldest note, pulse counts
    always @(posedge clk) rv <= rd;
    always @(negedge clk) begin
        if (rv) chk(rdata, exq.pop_front());
        n_rc += rc;
        n_tc += tc;
    end
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        foreach (ra[i]) rreg(ra[i], 8'h00);
        chk({1'b0, rdy_pwr, rc, tc, ovr, tv}, 8'h00);
        $display("reset test done");
        // every predivider code, random spare bits
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            wreg(12'h289, {r[7:2], k[1:0]});
            rreg(12'h289, {6'h00, k[1:0]});
            chk({6'h00, div}, {6'h00, k[1:0]});
        end
        $display("predivider test done");
        // a valid predivider is set up before the PLL is enabled
        wreg(12'h289, 8'h01);
        wreg(12'h280, 8'hff);
        wreg(12'h280, 8'hff);
        rreg(12'h280, 8'h07);
        chk({7'h00, rdy_pwr}, 8'h01);
        wreg(12'h280, 8'h01);
        wreg(12'h280, 8'h04);
        rreg(12'h280, 8'h04);
        chk(n_rc[7:0], 8'h02);
        $display("pll control test done");
        wreg(12'h2a7, 8'hff);
        wreg(12'h2a7, 8'hff);
        wreg(12'h2a7, 8'h00);
        wreg(12'h2a7, 8'h01);
        rreg(12'h2a7, 8'h01);
        chk(n_tc[7:0], 8'h02);
        $display("termination trigger test done");
        wreg(12'h281, 8'hff);
        for (int v = 0; v < 8; v++) begin
            r = $random(seed);
            code = r[2:0];
            wreg(12'h2a8, {r[7:5], 1'b1, v[2:0], r[0]});
            rreg(12'h2a8, {r[7:5], 1'b1, v[2:0], r[0]});
            chk({4'h0, ovr, tv}, {5'h01, v[2:0]});
        end
        $display("override test done");
        // calibrated code and status flags
        for (int n = 0; n < 4; n++) begin
            r = $random(seed);
            @(negedge clk);
            code = r[2:0];
            sts = r[6:3];
            wreg(12'h2a8, {r[7:5], 5'h00});
            repeat (3) @(negedge clk);
            chk({5'h00, tv}, {5'h00, r[2:0]});
            rreg(12'h281, {2'h0, r[6], r[5], r[4], 2'h0, r[3]});
        end
        $display("status test done");
        // mid-run reset clears stored bytes and level outputs
        wreg(12'h280, 8'h03);
        wreg(12'h2a8, 8'h1e);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        chk({1'b0, rdy_pwr, rc, tc, ovr, tv}, 8'h00);
        chk({6'h00, div}, 8'h00);
        rst = 1'b0;
        rreg(12'h280, 8'h00);
        rreg(12'h2a8, 8'h00);
        $display("mid-run reset test done");
        report_and_stop();
    end
    // watchdog well beyond the expected run
    initial begin
        #(2000 * 50);
        err_total++;
        report_and_stop();
    end
endmodule : tb_serdes_pll_term_cal_regs
`default_nettype wire
